/* rtl/mem_opt_pkg.sv */
// constants for the memory option port: register map, field layout, timing
package mem_opt_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ADDR_OFS = 8'h08;
	localparam logic [7:0] WDATA_OFS = 8'h0c;
	localparam logic [7:0] CMD_OFS = 8'h10;
	localparam logic [7:0] RDATA_OFS = 8'h14;
	// field positions
	localparam int CTRL_PTEST_BIT = 0;
	localparam int CTRL_RFEN_BIT = 1;
	localparam int STAT_GEN2_BIT = 0;
	localparam int STAT_PERR_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	localparam int STAT_RFSH_BIT = 3;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int ADDR_W = 20;
	// reset value of the control register and bus response codes
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing, in ns, and the clock period in ps
	localparam int CLK_PS = 5000;
	localparam int T_INIT_NS = 200;
	localparam int T_ROW_NS = 60;
	localparam int T_MUX_NS = 20;
	localparam int T_COL_NS = 80;
	localparam int T_END_NS = 40;
	localparam int T_RFREQ_NS = 20;
	localparam int T_RFRAS_NS = 100;
	localparam int T_RFDONE_NS = 20;
	localparam int T_RFINT_NS = 15600;
	// cycle counts, least times rounded up
	localparam logic [7:0] INIT_CYC = 8'((T_INIT_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] ROW_CYC = 8'((T_ROW_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] MUX_CYC = 8'((T_MUX_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] COL_CYC = 8'((T_COL_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] END_CYC = 8'((T_END_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RFREQ_CYC = 8'((T_RFREQ_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RFRAS_CYC = 8'((T_RFRAS_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] RFDONE_CYC = 8'((T_RFDONE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	// longest time between refreshes, rounded down
	localparam int RFINT_CYC = (T_RFINT_NS * 1000) / CLK_PS;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ROW = 3'b001,
		ST_MUX = 3'b010,
		ST_COL = 3'b011,
		ST_END = 3'b100,
		ST_RF_REQ = 3'b101,
		ST_RF_RAS = 3'b110,
		ST_RF_DONE = 3'b111
	} port_state_t;
endpackage : mem_opt_pkg

/* rtl/refresh_timer.sv */
// refresh interval timer: one-cycle pulse each time a refresh falls due
`timescale 1ns/10ps
`default_nettype none
module refresh_timer
	import mem_opt_pkg::*;
#(
	parameter int INTERVAL = RFINT_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enable,
	output logic due
);
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic due_reg;
	logic wrap;

	assign wrap = (count_reg == 16'(INTERVAL - 1));
	assign count_next = (!enable || wrap) ? 16'h0000 : count_reg + 16'h0001;
	assign due = due_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 16'h0000;
			due_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			due_reg <= enable && wrap;
		end
	end
endmodule : refresh_timer
`default_nettype wire

/* rtl/memory_option_port.sv */
// host side of the memory option header, with an AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module memory_option_port
	import mem_opt_pkg::*;
#(
	parameter int REFRESH_INTERVAL = RFINT_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [15:0] option_addr,
	output logic upper_addr_select,
	output logic row_strobe,
	output logic column_strobe,
	output logic refresh_row_strobe,
	output logic refresh_request_n,
	output logic refresh_complete,
	output logic parity_test,
	input wire logic parity_error_n,
	input wire logic option_type_strap,
	output logic private_cycle_n,
	output logic bank1_sel_or_addr_bit16,
	output logic bank2_sel_or_addr_bit17,
	output logic bank3_sel_or_addr_bit18,
	output logic addr_bit19,
	output logic init_n,
	output logic data_direction,
	output logic read_qualifier,
	output logic write_qualifier_n,
	input wire logic [7:0] option_data_line_in,
	output logic [7:0] option_data_line_out,
	output logic [7:0] option_data_line_oe
);
	// bus slave state
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	logic [7:0] awaddr_reg;
	logic aw_hi_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	// software-visible registers
	logic [1:0] ctrl_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0] wbyte_reg, rbyte_reg;
	logic perr_reg, gen2_reg, cmd_write_reg, cmd_pend_reg, rf_pend_reg;
	// port engine
	port_state_t state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [7:0] init_cnt_reg;
	logic init_n_reg;
	logic row_reg, col_reg, mux_reg, rfras_reg, rfreq_n_reg, rfdone_reg;
	logic rdq_reg, wrq_n_reg, dir_reg, priv_n_reg, drive_reg;
	logic [15:0] oaddr_reg;
	logic [2:0] dual_reg;
	logic a19_reg;

	// write decode
	logic do_wr, wr_ok, wr_ctrl, wr_stat, wr_addr, wr_wdat, wr_cmd;
	logic [31:0] wmask;
	assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_ok = !aw_hi_reg && (awaddr_reg[1:0] == 2'h0);
	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_ctrl = do_wr && wr_ok && (awaddr_reg == CTRL_OFS);
	assign wr_stat = do_wr && wr_ok && (awaddr_reg == STATUS_OFS) && wstrb_reg[0];
	assign wr_addr = do_wr && wr_ok && (awaddr_reg == ADDR_OFS);
	assign wr_wdat = do_wr && wr_ok && (awaddr_reg == WDATA_OFS) && wstrb_reg[0];
	assign wr_cmd = do_wr && wr_ok && (awaddr_reg == CMD_OFS) && wstrb_reg[0];
	logic wr_mapped;
	assign wr_mapped = wr_ok && (awaddr_reg <= RDATA_OFS);

	// read decode
	logic rd_take, rd_ok;
	logic [31:0] rd_word;
	logic [3:0] status_word;
	assign rd_take = s_axi_arvalid && !rvalid_reg;
	assign rd_ok = (s_axi_araddr[31:8] == 24'h000000) && (s_axi_araddr[1:0] == 2'h0);
	assign status_word = {rf_pend_reg || state_reg[2] && state_reg != ST_END,
		cmd_pend_reg || state_reg != ST_IDLE, perr_reg, gen2_reg};
	assign rd_word = !rd_ok ? 32'h00000000 :
		(s_axi_araddr[7:0] == CTRL_OFS) ? {30'h00000000, ctrl_reg} :
		(s_axi_araddr[7:0] == STATUS_OFS) ? {28'h0000000, status_word} :
		(s_axi_araddr[7:0] == ADDR_OFS) ? {12'h000, addr_reg} :
		(s_axi_araddr[7:0] == WDATA_OFS) ? {24'h000000, wbyte_reg} :
		(s_axi_araddr[7:0] == RDATA_OFS) ? {24'h000000, rbyte_reg} : 32'h00000000;
	logic rd_mapped;
	assign rd_mapped = rd_ok && (s_axi_araddr[7:0] <= RDATA_OFS);

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			aw_hi_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr[7:0];
				aw_hi_reg <= |s_axi_awaddr[31:8];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// software registers; a hardware set of the parity flag beats a clear
	logic perr_set, rf_due, cmd_take;
	assign perr_set = !parity_error_n && rdq_reg && col_reg;
	assign cmd_take = (state_reg == ST_IDLE) && init_n_reg && !rf_pend_reg && cmd_pend_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= CTRL_RST;
			addr_reg <= '0;
			wbyte_reg <= 8'h00;
			perr_reg <= 1'b0;
			cmd_pend_reg <= 1'b0;
			cmd_write_reg <= 1'b0;
		end else begin
			if (wr_ctrl && wstrb_reg[0])
				ctrl_reg <= wdata_reg[1:0];
			if (wr_addr)
				addr_reg <= (addr_reg & ~wmask[ADDR_W-1:0]) | (wdata_reg[ADDR_W-1:0] & wmask[ADDR_W-1:0]);
			if (wr_wdat)
				wbyte_reg <= wdata_reg[7:0];
			if (perr_set)
				perr_reg <= 1'b1;
			else if (wr_stat && wdata_reg[STAT_PERR_BIT])
				perr_reg <= 1'b0;
			// a start while an access is pending or running is dropped
			if (wr_cmd && wdata_reg[CMD_START_BIT] && !cmd_pend_reg && state_reg == ST_IDLE) begin
				cmd_pend_reg <= 1'b1;
				cmd_write_reg <= wdata_reg[CMD_WRITE_BIT];
			end else if (cmd_take) begin
				cmd_pend_reg <= 1'b0;
			end
		end
	end

	// init pulse after reset, then the strap is caught once
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			init_cnt_reg <= 8'h00;
			init_n_reg <= 1'b0;
			gen2_reg <= 1'b0;
		end else if (!init_n_reg) begin
			init_cnt_reg <= init_cnt_reg + 8'h01;
			if (init_cnt_reg == INIT_CYC - 8'h01) begin
				init_n_reg <= 1'b1;
				gen2_reg <= option_type_strap;
			end
		end
	end
	assign init_n = init_n_reg;

	refresh_timer #(
		.INTERVAL(REFRESH_INTERVAL)
	) u_timer (
		.clk(clk),
		.nrst(nrst),
		.enable(ctrl_reg[CTRL_RFEN_BIT] && init_n_reg),
		.due(rf_due)
	);

	// refresh wins over a pending access when both wait in idle
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg - 8'h01;
		case (state_reg)
			ST_IDLE: begin
				cnt_next = 8'h00;
				if (init_n_reg && rf_pend_reg) begin
					state_next = ST_RF_REQ;
					cnt_next = RFREQ_CYC - 8'h01;
				end else if (cmd_take) begin
					state_next = ST_ROW;
					cnt_next = ROW_CYC - 8'h01;
				end
			end
			ST_ROW: if (cnt_reg == 8'h00) begin
				state_next = ST_MUX;
				cnt_next = MUX_CYC - 8'h01;
			end
			ST_MUX: if (cnt_reg == 8'h00) begin
				state_next = ST_COL;
				cnt_next = COL_CYC - 8'h01;
			end
			ST_COL: if (cnt_reg == 8'h00) begin
				state_next = ST_END;
				cnt_next = END_CYC - 8'h01;
			end
			ST_RF_REQ: if (cnt_reg == 8'h00) begin
				state_next = ST_RF_RAS;
				cnt_next = RFRAS_CYC - 8'h01;
			end
			ST_RF_RAS: if (cnt_reg == 8'h00) begin
				state_next = ST_RF_DONE;
				cnt_next = RFDONE_CYC - 8'h01;
			end
			ST_END, ST_RF_DONE: if (cnt_reg == 8'h00) begin
				state_next = ST_IDLE;
				cnt_next = 8'h00;
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = 8'h00;
			end
		endcase
	end

	// pin values for the next state
	logic acc_n, in_acc, rd_n, wr_n;
	logic [2:0] dual_n;
	assign in_acc = (state_next == ST_ROW) || (state_next == ST_MUX) || (state_next == ST_COL);
	assign rd_n = in_acc && !cmd_write_reg;
	assign wr_n = in_acc && cmd_write_reg;
	assign acc_n = in_acc;

	// first generation: active-low bank selects; second: address bits
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_dual
			assign dual_n[gi] = gen2_reg ? addr_reg[16 + gi] :
				!(in_acc && addr_reg[17:16] == 2'(gi + 1));
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			rf_pend_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (rf_due)
				rf_pend_reg <= 1'b1;
			else if (state_reg == ST_RF_DONE && state_next == ST_IDLE)
				rf_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			row_reg <= 1'b0;
			mux_reg <= 1'b0;
			col_reg <= 1'b0;
			rfras_reg <= 1'b0;
			rfreq_n_reg <= 1'b1;
			rfdone_reg <= 1'b0;
			rdq_reg <= 1'b0;
			wrq_n_reg <= 1'b1;
			dir_reg <= 1'b1;
			priv_n_reg <= 1'b1;
			drive_reg <= 1'b0;
			oaddr_reg <= 16'h0000;
			dual_reg <= 3'h7;
			a19_reg <= 1'b0;
		end else begin
			row_reg <= in_acc;
			mux_reg <= (state_next == ST_MUX) || (state_next == ST_COL);
			col_reg <= state_next == ST_COL;
			rfras_reg <= state_next == ST_RF_RAS;
			rfreq_n_reg <= !((state_next == ST_RF_REQ) || (state_next == ST_RF_RAS));
			rfdone_reg <= state_next == ST_RF_DONE;
			rdq_reg <= rd_n;
			wrq_n_reg <= !wr_n;
			dir_reg <= !wr_n;
			priv_n_reg <= !acc_n;
			drive_reg <= wr_n && (state_next != ST_ROW);
			oaddr_reg <= addr_reg[15:0];
			dual_reg <= dual_n;
			a19_reg <= gen2_reg && addr_reg[19];
		end
	end

	// read byte captured at the end of the column phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rbyte_reg <= 8'h00;
		else if (state_reg == ST_COL && cnt_reg == 8'h00 && !cmd_write_reg)
			rbyte_reg <= option_data_line_in;
	end

	assign option_addr = oaddr_reg;
	assign upper_addr_select = mux_reg;
	assign row_strobe = row_reg;
	assign column_strobe = col_reg;
	assign refresh_row_strobe = rfras_reg;
	assign refresh_request_n = rfreq_n_reg;
	assign refresh_complete = rfdone_reg;
	assign parity_test = ctrl_reg[CTRL_PTEST_BIT];
	assign private_cycle_n = priv_n_reg;
	assign bank1_sel_or_addr_bit16 = dual_reg[0];
	assign bank2_sel_or_addr_bit17 = dual_reg[1];
	assign bank3_sel_or_addr_bit18 = dual_reg[2];
	assign addr_bit19 = a19_reg;
	assign data_direction = dir_reg;
	assign read_qualifier = rdq_reg;
	assign write_qualifier_n = wrq_n_reg;
	assign option_data_line_out = wbyte_reg;
	assign option_data_line_oe = {8{drive_reg}};
endmodule : memory_option_port
`default_nettype wire

/* verif/mem_opt_asserts.sv */
// timing and ordering checks on the memory option port pins
`timescale 1ns/10ps
`default_nettype none
module mem_opt_asserts (
	input wire logic clk,
	input wire logic nrst,
	input wire logic row_strobe,
	input wire logic column_strobe,
	input wire logic upper_addr_select,
	input wire logic refresh_row_strobe,
	input wire logic refresh_request_n,
	input wire logic refresh_complete,
	input wire logic init_n,
	input wire logic data_direction,
	input wire logic read_qualifier,
	input wire logic write_qualifier_n,
	input wire logic private_cycle_n,
	input wire logic [7:0] option_data_line_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	col_in_row_a: assert property (column_strobe |-> row_strobe && upper_addr_select)
		else $error("column strobe outside row phase");
	mux_lead_a: assert property ($rose(upper_addr_select) |-> !column_strobe ##4 column_strobe)
		else $error("upper address not shown four cycles before column");
	rf_alone_a: assert property (refresh_row_strobe |-> !refresh_request_n && !row_strobe)
		else $error("refresh strobe overlaps access or lacks request");
	rf_order_a: assert property ($fell(refresh_request_n) |-> ##4 refresh_row_strobe)
		else $error("refresh strobe not four cycles after request");
	rf_done_a: assert property ($fell(refresh_row_strobe) |-> refresh_complete)
		else $error("refresh done missing after strobe");
	init_quiet_a: assert property (!init_n |-> !row_strobe && refresh_request_n)
		else $error("option activity during initialize");
	wr_dir_a: assert property (!write_qualifier_n |-> !data_direction && !read_qualifier)
		else $error("write cycle with read direction");
	rd_qual_a: assert property (read_qualifier |-> row_strobe && !private_cycle_n && data_direction)
		else $error("read qualifier outside a read access");
	oe_write_a: assert property (|option_data_line_oe |-> !write_qualifier_n)
		else $error("data lines driven outside a write");
	row_hold_a: assert property ($rose(row_strobe) |-> row_strobe[*8])
		else $error("row strobe too short");
	rf_excl_a: assert property ((!refresh_request_n || refresh_complete) |-> !row_strobe && !column_strobe)
		else $error("access strobes during a refresh");
endmodule : mem_opt_asserts
bind memory_option_port mem_opt_asserts mem_opt_asserts_i (.clk, .nrst, .row_strobe,
	.column_strobe, .upper_addr_select, .refresh_row_strobe, .refresh_request_n,
	.refresh_complete, .init_n, .data_direction, .read_qualifier, .write_qualifier_n,
	.private_cycle_n, .option_data_line_oe);
`default_nettype wire

/* verif/mem_option_model.sv */
// behavioural plug-in memory option: byte store, data lines, parity fault
`timescale 1ns/10ps
`default_nettype none
module mem_option_model (
	input wire logic clk,
	input wire logic column_strobe,
	input wire logic read_qualifier,
	input wire logic write_qualifier_n,
	input wire logic [15:0] option_addr,
	input wire logic bank1_sel_or_addr_bit16,
	input wire logic bank2_sel_or_addr_bit17,
	input wire logic bank3_sel_or_addr_bit18,
	input wire logic addr_bit19,
	input wire logic [7:0] option_data_line_out,
	input wire logic [7:0] option_data_line_oe,
	input wire logic perr_inject,
	output logic [7:0] option_data_line_in,
	output logic parity_error_n
);
	logic [7:0] mem [0:4095];
	logic [7:0] last = 8'h5a;
	// stack decode uses the three dual pins and addr_bit19 together
	wire [11:0] idx = {addr_bit19, bank3_sel_or_addr_bit18, bank2_sel_or_addr_bit17,
		bank1_sel_or_addr_bit16, option_addr[7:0]};
	wire rd_on = column_strobe && read_qualifier;
	// released lines show the inverse, never a stale copy
	wire [7:0] drv = rd_on ? mem[idx] : ~last;
	always @(posedge clk) begin
		if (column_strobe && !write_qualifier_n)
			mem[idx] <= option_data_line_out;
		if (rd_on)
			last <= mem[idx];
	end
	assign option_data_line_in = (option_data_line_oe & option_data_line_out) |
		(~option_data_line_oe & drv);
	assign parity_error_n = !(rd_on && perr_inject);
endmodule : mem_option_model
`default_nettype wire

/* verif/tb_top.sv */
// testbench: register-driven accesses, refresh and strap handling
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import mem_opt_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
	logic clk = 0, nrst = 0, option_type_strap = 0, perr_inject = 0;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] option_addr;
	logic upper_addr_select, row_strobe, column_strobe, refresh_row_strobe, refresh_request_n;
	logic refresh_complete, parity_test, parity_error_n, private_cycle_n, addr_bit19, init_n;
	logic bank1_sel_or_addr_bit16, bank2_sel_or_addr_bit17, bank3_sel_or_addr_bit18;
	logic data_direction, read_qualifier, write_qualifier_n;
	logic [7:0] option_data_line_in, option_data_line_out, option_data_line_oe;
	int n_errors = 0, cmp_count = 0, cyc = 0;
	always #2.5 clk = ~clk;
	// bready and rready stay high: every answer is taken on its first cycle
	memory_option_port #(.REFRESH_INTERVAL(200)) memory_option_port_i (.clk, .nrst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready(1'b1), .option_addr, .upper_addr_select, .row_strobe,
		.column_strobe, .refresh_row_strobe, .refresh_request_n, .refresh_complete,
		.parity_test, .parity_error_n, .option_type_strap, .private_cycle_n,
		.bank1_sel_or_addr_bit16, .bank2_sel_or_addr_bit17, .bank3_sel_or_addr_bit18,
		.addr_bit19, .init_n, .data_direction, .read_qualifier, .write_qualifier_n,
		.option_data_line_in, .option_data_line_out, .option_data_line_oe);
	mem_option_model mem_option_model_i (.clk, .column_strobe, .read_qualifier,
		.write_qualifier_n, .option_addr, .bank1_sel_or_addr_bit16, .bank2_sel_or_addr_bit17,
		.bank3_sel_or_addr_bit18, .addr_bit19, .option_data_line_out, .option_data_line_oe,
		.perr_inject, .option_data_line_in, .parity_error_n);
	task automatic report_and_stop;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axi_rd
	task automatic access(input logic [19:0] a, input logic w, input logic [7:0] d,
		input logic g);
		logic [31:0] v;
		logic [1:0] r;
		axi_wr(32'(ADDR_OFS), {12'h0, a});
		axi_wr(32'(WDATA_OFS), {24'h0, d});
		axi_wr(32'(CMD_OFS), {30'h0, w, 1'b1});
		while (column_strobe !== 1'b1)
			@(posedge clk);
		`CHK(option_addr[15:10], a[15:10])
		`CHK({row_strobe, upper_addr_select}, 2'h3)
		`CHK({data_direction, read_qualifier, write_qualifier_n}, {3{~w}})
		`CHK(private_cycle_n, 1'b0)
		`CHK({addr_bit19, bank3_sel_or_addr_bit18, bank2_sel_or_addr_bit17,
			bank1_sel_or_addr_bit16}, g ? a[19:16] : {1'b0, a[17:16] != 2'h3,
			a[17:16] != 2'h2, a[17:16] != 2'h1})
		`CHK(option_data_line_oe, {8{w}})
		do
			axi_rd(32'(STATUS_OFS), v, r);
		while (v[STAT_BUSY_BIT] !== 1'b0);
		axi_rd(32'(RDATA_OFS), v, r);
		if (!w)
			`CHK(v[7:0], d)
	endtask : access
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			report_and_stop;
		end
	end
	initial begin
		logic [31:0] rv;
		logic [1:0] rr;
		logic [19:0] a;
		int n;
		for (int g = 0; g < 2; g++) begin
			option_type_strap <= g[0];
			nrst <= 1'b0;
			repeat (8) @(posedge clk);
			nrst <= 1'b1;
			// pins the rise of init_n to the 40th edge after release
			repeat (40) @(posedge clk);
			`CHK(init_n, 1'b0)
			repeat (1) @(posedge clk);
			`CHK(init_n, 1'b1)
			// a strap that moves after init must not change the pin roles
			option_type_strap <= ~g[0];
			axi_wr(32'(CTRL_OFS), 32'h0);
			axi_rd(32'(STATUS_OFS), rv, rr);
			`CHK(rv[STAT_GEN2_BIT], g[0])
			`CHK(parity_test, 1'b0)
			for (int k = 0; k < 4; k++) begin
				a = {4'(k * 5), 16'ha5c0 | 16'(k)};
				access(a, 1'b1, 8'h3c ^ 8'(k * 17), g[0]);
				access(a, 1'b0, 8'h3c ^ 8'(k * 17), g[0]);
			end
		end
		perr_inject <= 1'b1;
		access(a, 1'b0, 8'h0f, 1'b1);
		perr_inject <= 1'b0;
		axi_rd(32'(STATUS_OFS), rv, rr);
		`CHK(rv[STAT_PERR_BIT], 1'b1)
		axi_wr(32'(STATUS_OFS), 32'h2);
		axi_rd(32'(STATUS_OFS), rv, rr);
		`CHK(rv[STAT_PERR_BIT], 1'b0)
		axi_wr(32'(CTRL_OFS), 32'h1);
		`CHK(s_axi_bresp, RESP_OKAY)
		`CHK(parity_test, 1'b1)
		axi_wr(32'(CTRL_OFS), 32'h2);
		access(a, 1'b0, 8'h0f, 1'b1);
		while (refresh_row_strobe !== 1'b1)
			@(posedge clk);
		n = 0;
		while (refresh_row_strobe === 1'b1) begin
			n++;
			@(posedge clk);
		end
		`CHK(n, 20)
		`CHK({refresh_complete, refresh_request_n}, 2'h3)
		// still in the done phase: refresh and busy both show
		axi_rd(32'(STATUS_OFS), rv, rr);
		`CHK({rv[STAT_RFSH_BIT], rv[STAT_BUSY_BIT]}, 2'h3)
		axi_rd(32'h18, rv, rr);
		`CHK(rr, RESP_SLVERR)
		`CHK(rv, 32'h0)
		axi_wr(32'h18, 32'h1);
		`CHK(s_axi_bresp, RESP_SLVERR)
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
